// ---- usbev_params.svh ----
// constants of the endpoint validity and halt block
// assumes inclusion by bare name from the package and the design files
`ifndef USBEV_PARAMS_SVH
`define USBEV_PARAMS_SVH

// register indices; the byte address is four times the index
`define USBEV_MAP_IDX    32'h0020_0086
`define USBEV_HALT_IDX   32'h0020_015C
`define USBEV_MAP_RST    8'h00
`define USBEV_HALT_RST   8'h00

// endpoint 1 interface map fields
`define USBEV_LINK_MSB   7
`define USBEV_LINK_LSB   5
`define USBEV_TWO_BIT    4
`define USBEV_FIVE_MSB   3
`define USBEV_FIVE_LSB   0

// endpoint 4 halt status fields
`define USBEV_HALT_BIT   0

// interface count and alternate setting range
`define USBEV_NUM_IFACE  5
`define USBEV_NUM_ALT5   4

// timing: one wait state on every bus access
`define USBEV_APB_WAIT   1

`endif

// ---- usbev_pkg.sv ----
// types of the endpoint validity and halt block
// assumes usbev_params.svh sits in the same folder
`include "usbev_params.svh"

package usbev_pkg;

  typedef enum logic [2:0] {
    LINK_NONE   = 3'b000,
    LINK_IF0    = 3'b001,
    LINK_IF1    = 3'b010,
    LINK_IF2    = 3'b011,
    LINK_IF3    = 3'b100,
    LINK_IF4    = 3'b101,
    LINK_BAD6   = 3'b110,
    LINK_BAD7   = 3'b111
  } usbev_link_type;

  typedef struct packed {
    usbev_link_type link;
    logic           two_alt1;
    logic [3:0]     five_alt;
  } usbev_map_type;

  // one-cycle strobes from the protocol engine
  typedef struct packed {
    logic       ep4_error;
    logic       set_feature_halt;
    logic       clear_feature_halt;
    logic       set_configuration;
    logic       set_interface;
    logic       toggle_reinit;
    logic [2:0] iface;
    logic [2:0] alt;
  } usbev_req_type;

endpackage

// ---- usbev_ep1_valid.sv ----
// endpoint 1 validity decision from map, alternate settings and configured flag
// assumes request strobes come from logic on pclk
`timescale 1ns/10ps
`default_nettype none
`include "usbev_params.svh"

module usbev_ep1_valid (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // configuration
  input  wire usbev_pkg::usbev_map_type map,
  input  wire logic                   configured_flag,
  input  wire usbev_pkg::usbev_req_type req,
  // result
  output logic                        ep1_valid_ff
);

  // --------------------------------------------------------------
  // alternate setting per interface
  // --------------------------------------------------------------
  logic [2:0] alt_ff [`USBEV_NUM_IFACE];
  genvar gi;
  generate
    for (gi = 0; gi < `USBEV_NUM_IFACE; gi = gi + 1) begin : g_if
      wire logic hit = req.set_interface && (req.iface == 3'(gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          alt_ff[gi] <= 3'h0;
        end else if (req.set_configuration) begin
          alt_ff[gi] <= 3'h0;
        end else if (hit) begin
          alt_ff[gi] <= req.alt;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  // 110 and 111 count as unlinked, whatever the other bits say
  wire logic       linked = (map.link >= usbev_pkg::LINK_IF0) &&
                            (map.link <= usbev_pkg::LINK_IF4);
  wire logic [2:0] if_idx = linked ? 3'(map.link - 3'h1) : 3'h0;
  wire logic [2:0] cur_alt = alt_ff[if_idx];
  wire logic       five_any = |map.five_alt;
  logic [3:0]      five_hit;
  generate
    for (gi = 0; gi < `USBEV_NUM_ALT5; gi = gi + 1) begin : g_alt
      assign five_hit[gi] = map.five_alt[gi] && (cur_alt == 3'(gi + 1));
    end
  endgenerate
  // alt 0 always valid once linked and configured; two-series bit only when five bits are 0000
  wire logic alt_ok = (cur_alt == 3'h0) ||
                      (five_any ? |five_hit
                                : (map.two_alt1 && cur_alt == 3'h1));
  wire logic nxt_ep1_valid = linked && configured_flag && alt_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep1_valid_ff <= 1'b0;
    end else begin
      ep1_valid_ff <= nxt_ep1_valid;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  bad_link_a : assert property (@(posedge pclk) disable iff (!presetn)
    map.link inside {usbev_pkg::LINK_BAD6, usbev_pkg::LINK_BAD7, usbev_pkg::LINK_NONE}
    |=> !ep1_valid_ff)
    else $error("endpoint 1 valid while unlinked");
  configured_flag_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
    !configured_flag |=> !ep1_valid_ff)
    else $error("endpoint 1 valid while not configured");
  alt0_valid_a : assert property (@(posedge pclk) disable iff (!presetn)
    (linked && configured_flag && cur_alt == 3'h0) |=> ep1_valid_ff)
    else $error("linked endpoint 1 invalid at alternate setting 0");
  two_series_a : assert property (@(posedge pclk) disable iff (!presetn)
    (linked && configured_flag && five_any && cur_alt == 3'h1 && !map.five_alt[0])
    |=> !ep1_valid_ff)
    else $error("two-series bit honoured while five-series bits set");
  five_series_a : assert property (@(posedge pclk) disable iff (!presetn)
    (linked && configured_flag && cur_alt == 3'h3 && map.five_alt[2]) |=> ep1_valid_ff)
    else $error("five-series alternate setting 3 not validated");
  alt1_cv : cover property (@(posedge pclk) disable iff (!presetn)
    ep1_valid_ff && cur_alt == 3'h1 && !five_any);

endmodule
`default_nettype wire

// ---- usbev_top.sv ----
// endpoint 1 validity and endpoint 4 halt status, with an apb register slave
// assumes protocol strobes and status inputs are synchronous to pclk
// Summary of operation
// - link field: 1-5 interfaces 0-4, else none
// - linked, configured endpoint always valid at alt 0
// - endpoint 1 valid only when linked and configured
// - two-series bit validates alternate setting 1
// - two-series bit only when five bits zero
// - five-series bit n validates alternate setting n+1
// - endpoint 1 requests answered from current validity
// - halt register written only under nak-all
// - any endpoint 4 error sets halt
// - writes dropped during endpoint 4 usb activity
// - get status returns halt register contents
// - stalling clears bulk-out buffer and nak
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "usbev_params.svh"

module usbev_top #(
  parameter logic [2:0] EP4_IFACE = 3'h0
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // controller state
  input  wire logic                    configured_flag,
  input  wire logic                    ep0_nak_all,
  // protocol engine strobes and endpoint 4 activity levels
  input  wire usbev_pkg::usbev_req_type usb_req,
  input  wire logic                    ep4_rx_busy,
  input  wire logic                    ep4_data_xfer,
  input  wire logic                    ep4_get_status,
  input  wire logic                    ep1_request,
  // answers to the protocol engine
  output logic                         ep1_valid,
  output logic                         ep1_accept,
  output logic                         ep1_stall,
  output logic                         ep4_status_valid,
  output logic [7:0]                   ep4_status_data,
  output logic                         bulk_out_buffer_two_clear,
  output logic                         bulk_out_two_nak_clear
);

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  localparam logic [31:0] MAP_ADDR  = 32'(`USBEV_MAP_IDX * 4);
  localparam logic [31:0] HALT_ADDR = 32'(`USBEV_HALT_IDX * 4);

  usbev_pkg::usbev_map_type map_ff;
  logic                     halt_ff;
  logic                     pready_ff;
  logic [31:0]              prdata_ff;
  logic                     pslverr_ff;

  wire logic sel_map   = (paddr == MAP_ADDR);
  wire logic sel_halt  = (paddr == HALT_ADDR);
  wire logic mapped    = sel_map || sel_halt;
  // one wait state: the answer is prepared while pready is low
  wire logic acc_wait  = psel && penable && !pready_ff;
  wire logic acc_done  = psel && penable && pready_ff;
  wire logic wr_map    = acc_done && pwrite && sel_map;
  wire logic wr_halt   = acc_done && pwrite && sel_halt;
  wire logic [7:0] halt_byte = {7'h00, halt_ff};
  wire logic [31:0] rd_word = sel_map  ? {24'h000000, map_ff} :
                              sel_halt ? {24'h000000, halt_byte} : 32'h0000_0000;

  wire logic nxt_pready  = acc_wait;
  wire logic [31:0] nxt_prdata = (acc_wait && !pwrite) ? rd_word : 32'h0000_0000;
  wire logic nxt_pslverr = acc_wait && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_ff <= usbev_pkg::usbev_map_type'(`USBEV_MAP_RST);
    end else if (wr_map) begin
      map_ff <= usbev_pkg::usbev_map_type'(pwdata[7:0]);
    end
  end

  // --------------------------------------------------------------
  // endpoint 4 halt flag
  // --------------------------------------------------------------
  // software writes race the usb side, so endpoint 4 receive or data activity masks them
  wire logic sw_ok = wr_halt && ep0_nak_all
                     && !ep4_rx_busy && !ep4_data_xfer;
  wire logic hw_set = usb_req.ep4_error
                      || usb_req.set_feature_halt;
  wire logic iface_clr = usb_req.set_interface && (usb_req.iface == EP4_IFACE);
  wire logic hw_clr = usb_req.clear_feature_halt || usb_req.set_configuration
                      || iface_clr || usb_req.toggle_reinit;
  // hardware set beats every clear, hardware clear beats software
  wire logic nxt_halt = hw_set ? 1'b1 :
                        hw_clr ? 1'b0 :
                        sw_ok  ? pwdata[`USBEV_HALT_BIT] : halt_ff;
  wire logic stall_entry = nxt_halt && !halt_ff;

  logic       buf_clr_ff;
  logic       nak_clr_ff;
  logic       st_valid_ff;
  logic [7:0] st_data_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_ff     <= 1'(`USBEV_HALT_RST >> `USBEV_HALT_BIT);
      buf_clr_ff  <= 1'b0;
      nak_clr_ff  <= 1'b0;
      st_valid_ff <= 1'b0;
      st_data_ff  <= 8'h00;
    end else begin
      halt_ff     <= nxt_halt;
      buf_clr_ff  <= stall_entry;
      nak_clr_ff  <= stall_entry;
      st_valid_ff <= ep4_get_status;
      st_data_ff  <= ep4_get_status ? halt_byte : 8'h00;
    end
  end

  // --------------------------------------------------------------
  // endpoint 1
  // --------------------------------------------------------------
  logic ep1_valid_int;
  logic ep1_acc_ff;
  logic ep1_stl_ff;

  usbev_ep1_valid u_ep1 (
    .pclk            (pclk),
    .presetn         (presetn),
    .map             (map_ff),
    .configured_flag (configured_flag),
    .req             (usb_req),
    .ep1_valid_ff    (ep1_valid_int)
  );

  // an invalid endpoint is answered with a stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep1_acc_ff <= 1'b0;
      ep1_stl_ff <= 1'b0;
    end else begin
      ep1_acc_ff <= ep1_request && ep1_valid_int;
      ep1_stl_ff <= ep1_request && !ep1_valid_int;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign pready                    = pready_ff;
  assign prdata                    = prdata_ff;
  assign pslverr                   = pslverr_ff;
  assign ep1_valid                 = ep1_valid_int;
  assign ep1_accept                = ep1_acc_ff;
  assign ep1_stall                 = ep1_stl_ff;
  assign ep4_status_valid          = st_valid_ff;
  assign ep4_status_data           = st_data_ff;
  assign bulk_out_buffer_two_clear = buf_clr_ff;
  assign bulk_out_two_nak_clear    = nak_clr_ff;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  nak_all_mask_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_halt && !ep0_nak_all && !hw_set && !hw_clr) |=> $stable(halt_ff))
    else $error("halt written without nak-all");
  busy_mask_a : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_halt && (ep4_rx_busy || ep4_data_xfer) && !hw_set && !hw_clr)
    |=> $stable(halt_ff))
    else $error("halt written during endpoint 4 activity");
  write_take_a : assert property (@(posedge pclk) disable iff (!presetn)
    (sw_ok && !hw_set && !hw_clr) |=> (halt_ff == $past(pwdata[0])))
    else $error("accepted halt write not stored");
  error_halt_a : assert property (@(posedge pclk) disable iff (!presetn)
    usb_req.ep4_error |=> halt_ff)
    else $error("endpoint 4 error did not halt");
  hw_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
    (hw_clr && !hw_set) |=> !halt_ff)
    else $error("halt not cleared by request");
  get_status_a : assert property (@(posedge pclk) disable iff (!presetn)
    ep4_get_status |=> ep4_status_valid && ep4_status_data == {7'h00, $past(halt_ff)})
    else $error("get status returned wrong contents");
  stall_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(halt_ff) |-> bulk_out_buffer_two_clear && bulk_out_two_nak_clear)
    else $error("stall did not clear bulk-out buffer");
  reserved_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && sel_halt) |-> prdata[31:1] == 31'h0000_0000)
    else $error("reserved halt bits not zero");
  ep1_answer_a : assert property (@(posedge pclk) disable iff (!presetn)
    ep1_request |=> (ep1_accept == $past(ep1_valid_int)) && (ep1_stall != ep1_accept))
    else $error("endpoint 1 answer disagrees with validity");
  apb_wait_a : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");

  // set beats clear, and the nak clear pulse only ever marks a fresh stall
  set_wins_a : assert property (@(posedge pclk) disable iff (!presetn)
    (hw_set && hw_clr) |=> halt_ff)
    else $error("halt clear beat a halt set");
  nak_pulse_a : assert property (@(posedge pclk) disable iff (!presetn)
    bulk_out_two_nak_clear |-> $rose(halt_ff))
    else $error("bulk-out nak cleared without stall entry");
  map_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr_map |=> (map_ff == $past(pwdata[7:0])))
    else $error("map write not stored");
  unmapped_err_a : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !mapped) |-> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  halt_write_cv : cover property (@(posedge pclk) disable iff (!presetn)
    sw_ok && pwdata[0]);
  error_stall_cv : cover property (@(posedge pclk) disable iff (!presetn)
    usb_req.ep4_error ##1 ep4_get_status);
  ep1_valid_cv : cover property (@(posedge pclk) disable iff (!presetn)
    ep1_request && ep1_valid_int);
  masked_cv : cover property (@(posedge pclk) disable iff (!presetn)
    wr_halt && ep4_data_xfer);

endmodule
`default_nettype wire

// ---- usbev_host_model.sv ----
// host-side model: drives the protocol strobes and controller state levels
// assumes pclk from the bench; every change follows a rising edge by nba
`timescale 1ns/10ps
`default_nettype none

module usbev_host_model (
  // clock
  input  wire logic               pclk,
  // controller state levels
  output logic                    configured_flag,
  output logic                    ep0_nak_all,
  output logic                    ep4_rx_busy,
  output logic                    ep4_data_xfer,
  // one-cycle strobes
  output usbev_pkg::usbev_req_type usb_req,
  output logic                    ep4_get_status,
  output logic                    ep1_request
);
  initial begin
    configured_flag = 1'b0;
    ep0_nak_all     = 1'b0;
    ep4_rx_busy     = 1'b0;
    ep4_data_xfer   = 1'b0;
    usb_req         = '0;
    ep4_get_status  = 1'b0;
    ep1_request     = 1'b0;
  end

  task automatic levels(input logic cfg, nak, busy, xfer);
    @(posedge pclk);
    configured_flag <= cfg;
    ep0_nak_all     <= nak;
    ep4_rx_busy     <= busy;
    ep4_data_xfer   <= xfer;
  endtask

  // strobes stand exactly one cycle, as the engine issues them
  task automatic pulse(input logic [5:0] ev, input logic [2:0] ifc, alt, input logic gs, e1);
    @(posedge pclk);
    usb_req        <= usbev_pkg::usbev_req_type'({ev, ifc, alt});
    ep4_get_status <= gs;
    ep1_request    <= e1;
    @(posedge pclk);
    usb_req        <= '0;
    ep4_get_status <= 1'b0;
    ep1_request    <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- usbev_tb_top.sv ----
// self-checking bench of the endpoint validity and halt block
// assumes the design files and the host model are compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "usbev_params.svh"

module usbev_tb_top;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0]              paddr, pwdata, prdata;
  logic                     configured_flag, ep0_nak_all, ep4_rx_busy, ep4_data_xfer;
  usbev_pkg::usbev_req_type usb_req;
  logic                     ep4_get_status, ep1_request, ep1_valid, ep1_accept, ep1_stall;
  logic                     ep4_status_valid, bo_clr, nak_clr;
  logic [7:0]               ep4_status_data;
  int                       miscompares, n_checks;
  localparam logic [31:0]   MAP_A  = `USBEV_MAP_IDX << 2;
  localparam logic [31:0]   HALT_A = `USBEV_HALT_IDX << 2;

  usbev_top #(.EP4_IFACE(3'h0)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .configured_flag(configured_flag),
    .ep0_nak_all(ep0_nak_all), .usb_req(usb_req), .ep4_rx_busy(ep4_rx_busy),
    .ep4_data_xfer(ep4_data_xfer), .ep4_get_status(ep4_get_status),
    .ep1_request(ep1_request), .ep1_valid(ep1_valid), .ep1_accept(ep1_accept),
    .ep1_stall(ep1_stall), .ep4_status_valid(ep4_status_valid),
    .ep4_status_data(ep4_status_data), .bulk_out_buffer_two_clear(bo_clr),
    .bulk_out_two_nak_clear(nak_clr));

  usbev_host_model i_host (.pclk(pclk), .configured_flag(configured_flag),
    .ep0_nak_all(ep0_nak_all), .ep4_rx_busy(ep4_rx_busy), .ep4_data_xfer(ep4_data_xfer),
    .usb_req(usb_req), .ep4_get_status(ep4_get_status), .ep1_request(ep1_request));

  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held from setup until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    chk(n < 20, 1'b1, "pready timeout");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [31:0] a, exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk(e, experr, "slave error");
  endtask

  // pulses land on the edge that samples the strobe, and three cycles are watched
  task automatic look(output logic [4:0] s, output logic [7:0] d);
    s = '0;
    d = 8'h00;
    repeat (3) begin
      #1;
      s |= {ep1_accept, ep1_stall, ep4_status_valid, bo_clr, nak_clr};
      if (ep4_status_valid === 1'b1) d = ep4_status_data;
      @(posedge pclk);
    end
  endtask

  task automatic ev1(input logic exp);
    logic [4:0] s;
    logic [7:0] d;
    repeat (4) @(posedge pclk);
    chk(ep1_valid, exp, "ep1 valid");
    i_host.pulse(6'h00, 3'h0, 3'h0, 1'b0, 1'b1);
    look(s, d);
    chk(s[4:3], exp ? 2'b10 : 2'b01, "ep1 answer");
  endtask

  task automatic t_regs;
    rd(MAP_A, 32'h0, 1'b0);
    rd(HALT_A, 32'h0, 1'b0);
    wr(MAP_A + 32'h4, 32'hFF);
    rd(MAP_A + 32'h4, 32'h0, 1'b1);
    rd(MAP_A, 32'h0, 1'b0);
  endtask

  task automatic t_link;
    i_host.levels(1'b1, 1'b0, 1'b0, 1'b0);
    i_host.pulse(6'h04, 3'h0, 3'h0, 1'b0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      wr(MAP_A, {24'h0, 3'(k), 5'h00});
      rd(MAP_A, {24'h0, 3'(k), 5'h00}, 1'b0);
      ev1(k >= 1 && k <= 5);
    end
    wr(MAP_A, 32'h20);
    i_host.levels(1'b0, 1'b0, 1'b0, 1'b0);
    ev1(1'b0);
    i_host.levels(1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_alt;
    i_host.pulse(6'h02, 3'h1, 3'h1, 1'b0, 1'b0);
    wr(MAP_A, 32'h50);
    ev1(1'b1);
    wr(MAP_A, 32'h40);
    ev1(1'b0);
    wr(MAP_A, 32'h52);
    ev1(1'b0);
    for (int n = 1; n <= 4; n++) begin
      i_host.pulse(6'h02, 3'h1, 3'(n), 1'b0, 1'b0);
      wr(MAP_A, {24'h0, 4'h4, 4'(1 << (n - 1))});
      ev1(1'b1);
      wr(MAP_A, {24'h0, 4'h4, 4'hF & ~4'(1 << (n - 1))});
      ev1(1'b0);
    end
    i_host.pulse(6'h02, 3'h1, 3'h0, 1'b0, 1'b0);
    wr(MAP_A, 32'h4F);
    ev1(1'b1);
  endtask

  task automatic t_halt_sw;
    wr(HALT_A, 32'h01);
    rd(HALT_A, 32'h0, 1'b0);
    i_host.levels(1'b1, 1'b1, 1'b0, 1'b0);
    wr(HALT_A, 32'hFF);
    rd(HALT_A, 32'h01, 1'b0);
    wr(HALT_A, 32'h00);
    rd(HALT_A, 32'h0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      i_host.levels(1'b1, 1'b1, k == 0, k == 1);
      wr(HALT_A, 32'h01);
      rd(HALT_A, 32'h0, 1'b0);
    end
    i_host.levels(1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_halt_hw;
    logic [4:0] s;
    logic [7:0] d;
    logic [5:0] clr_ev [4] = '{6'h08, 6'h04, 6'h02, 6'h01};
    for (int k = 0; k < 4; k++) begin
      i_host.pulse(k == 0 ? 6'h20 : 6'h10, 3'h0, 3'h0, 1'b0, 1'b0);
      look(s, d);
      chk(s[1:0], 2'b11, "stall clears bulk out");
      rd(HALT_A, 32'h01, 1'b0);
      i_host.pulse(6'h28, 3'h0, 3'h0, 1'b0, 1'b0);
      look(s, d);
      chk(s[1:0], 2'b00, "no clear pulse while halted");
      i_host.pulse(6'h00, 3'h0, 3'h0, 1'b1, 1'b0);
      look(s, d);
      chk({s[2], d}, 9'h101, "status set");
      i_host.pulse(clr_ev[k], 3'h0, 3'h0, 1'b0, 1'b0);
      rd(HALT_A, 32'h00, 1'b0);
      i_host.pulse(6'h00, 3'h0, 3'h0, 1'b1, 1'b0);
      look(s, d);
      chk({s[2], d}, 9'h100, "status clear");
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // whole run needs well under a thousand cycles
  initial begin
    #(3000 * 40);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_link();
    t_alt();
    t_halt_sw();
    t_halt_hw();
    report_and_stop();
  end
endmodule

`default_nettype wire
